// file: hw/fsrfc_ctrl.sv
// Status register four controller: power-down, program modes, errors, continuous read
// How it works
// [R1] With the depth select at 0 the power-down command enters ultra-deep power-down and drops the buffer.
// [R2] With the depth select at 1 the power-down command enters deep power-down and keeps the buffer.
// [R3] Only the resume command brings the device out of either power-down state.
// [R4] Chip select pulses without the resume command leave the device asleep.
// [R5] Reset leaves byte/page program mode with the sequential flag at 0; it reads 1 once that mode is entered.
// [R6] Sequential program takes an address on its first frame only and then runs on from the held address.
// [R7] A failed program sets the program error flag at bit 5.
// [R8] A failed erase sets the erase error flag at bit 4.
// [R9] The continuous-read enable at bit 3 is writable and starts at 0.
// [R10] With continuous read on, later quad reads carry only address and data on four lines.
// [R11] The first quad read frame takes its command on the single input line, the rest on four lines.
// [R12] Without both continuous-read enable and quad enable every frame needs a command.
// [R13] The burst wrap field mirrors the wrap control bits of the set wrap command and starts at 001.
// [R14] Every byte moves most significant bit first.
// [R15] With quad enable set the hold/reset pin function is turned off.
// [R16] The program error flag holds until the next program starts, the erase error flag until the next erase starts, or a reset.
`timescale 1ns/1ps
module fsrfc_ctrl import fsrfc_pkg::*; (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic [3:0] io_in,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   input wire logic quad_enable,
   input wire logic prog_fail,
   input wire logic erase_fail,
   output logic prog_req_q,
   output logic [23:0] prog_addr_q,
   output logic [7:0] prog_data_q,
   output logic erase_req_q,
   output logic [7:0] erase_cmd_q,
   output logic [23:0] erase_addr_q,
   output logic read_req_q,
   output logic [23:0] read_addr_q,
   output logic deep_power_down_q,
   output logic ultra_deep_power_down_q,
   output logic sram_retain_q,
   output logic hold_reset_enable_q,
   output logic [7:0] status_q
);
   logic [7:0] cmd_q, data_q;
   logic [23:0] addr_q;
   logic [2:0] nbytes_q;
   logic xip_frame_q, frame_tog_q;

   fsrfc_link u_link (
      .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n),
      .sys_rst(sys_rst),
      .io_in(io_in),
      .status_in(status_q),
      .quad_enable(quad_enable),
      .io_out(io_out),
      .io_oe(io_oe),
      .cmd_q(cmd_q),
      .addr_q(addr_q),
      .data_q(data_q),
      .nbytes_q(nbytes_q),
      .xip_frame_q(xip_frame_q),
      .frame_tog_q(frame_tog_q)
   );

   // Frame end: chip select rise through two flops
   logic cs_s1_q, cs_s2_q, cs_s3_q, tog_seen_q;
   logic frame_end;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         tog_seen_q <= 1'b0;
      end else begin
         cs_s1_q <= spi_cs_n;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         tog_seen_q <= frame_end ? frame_tog_q : tog_seen_q;
      end
   end

   // A select pulse with no clock edges must not replay the last frame
   assign frame_end = cs_s2_q & ~cs_s3_q & (frame_tog_q ^ tog_seen_q);

   // Register state
   fsrfc_power_type pwr_q, pwr_d;
   logic pdm_q, pdm_d;
   logic xip_q, xip_d;
   logic seq_q, seq_d;
   logic perr_q, perr_d;
   logic eerr_q, eerr_d;
   logic [2:0] wrap_q, wrap_d;
   logic [23:0] seq_addr_q, seq_addr_d;
   logic [7:0] status_d;

   // Command decode at frame end
   logic active, cmd_frame, fr_ok;
   logic has_cmd, has_one, has_addr, has_data;
   logic is_erase, is_qread;
   logic do_wrsr, do_wrap, do_pd, do_ultra_deep_power_down, do_resume;
   logic do_page, do_seq_first, do_seq_next, do_wrdi;
   logic do_erase, do_read, prog_start;
   logic [7:0] wr_byte;

   assign active = (pwr_q == PWR_ACTIVE);
   assign cmd_frame = frame_end & ~xip_frame_q;
   assign fr_ok = cmd_frame & active;
   assign has_cmd = (nbytes_q >= NB_CMD);
   assign has_one = (nbytes_q >= NB_ONE);
   assign has_addr = (nbytes_q >= NB_ADDR);
   assign has_data = (nbytes_q >= NB_DATA);
   assign wr_byte = addr_q[23:16];
   assign is_erase = (cmd_q == CMD_ERASE_4K) | (cmd_q == CMD_ERASE_32K) | (cmd_q == CMD_ERASE_64K);
   assign is_qread = (cmd_q == CMD_QREAD_E7) | (cmd_q == CMD_QREAD_EB);
   assign do_wrsr = fr_ok & (cmd_q == CMD_WRITE_SR4) & has_one;
   assign do_wrap = fr_ok & (cmd_q == CMD_SET_WRAP) & has_data;
   assign do_pd = fr_ok & (cmd_q == CMD_POWER_DOWN) & has_cmd;
   assign do_ultra_deep_power_down = fr_ok & (cmd_q == CMD_ULTRA_DEEP) & has_cmd;
   assign do_resume = cmd_frame & ~active & (cmd_q == CMD_RESUME) & has_cmd; // R3 R4
   assign do_page = fr_ok & (cmd_q == CMD_PAGE_PROG) & has_data;
   assign do_seq_first = fr_ok & (cmd_q == CMD_SEQ_PROG) & ~seq_q & has_data; // R6
   assign do_seq_next = fr_ok & (cmd_q == CMD_SEQ_PROG) & seq_q & has_one; // R6
   assign do_wrdi = fr_ok & (cmd_q == CMD_WRITE_DISABLE) & has_cmd;
   assign do_erase = fr_ok & ((is_erase & has_addr) | ((cmd_q == CMD_ERASE_CHIP) & has_cmd));
   // Quad reads need quad enable; command-less frames come only from the link
   assign do_read = frame_end & active & has_addr & quad_enable & (xip_frame_q | is_qread); // R12
   assign prog_start = do_page | do_seq_first | do_seq_next;

   // Next values
   assign pdm_d = do_wrsr ? wr_byte[SR4_PDM_BIT] : pdm_q;
   assign xip_d = do_wrsr ? wr_byte[SR4_XIP_BIT] : xip_q; // R9
   assign wrap_d = do_wrap ? data_q[WRAP_CTRL_LSB +: WRAP_W] : wrap_q; // R13
   assign seq_d = do_seq_first ? 1'b1 : (do_wrdi ? 1'b0 : seq_q); // R5
   // Set wins over the clear by a new start
   assign perr_d = prog_fail | (perr_q & ~prog_start); // R7 R16
   assign eerr_d = erase_fail | (eerr_q & ~do_erase); // R8 R16
   assign seq_addr_d = do_seq_first ? addr_q + 24'h1 : (do_seq_next ? seq_addr_q + 24'h1 : seq_addr_q);

   always_comb begin
      pwr_d = pwr_q;
      case (pwr_q)
         PWR_ACTIVE: begin
            if (do_ultra_deep_power_down) begin
               pwr_d = PWR_ULTRA;
            end else if (do_pd) begin
               pwr_d = pdm_q ? PWR_DEEP : PWR_ULTRA; // R1 R2
            end
         end
         PWR_DEEP, PWR_ULTRA: begin
            if (do_resume) begin
               pwr_d = PWR_ACTIVE; // R3
            end
         end
         default: pwr_d = PWR_ACTIVE;
      endcase
   end

   always_comb begin
      status_d = 8'h00;
      status_d[SR4_PDM_BIT] = pdm_d;
      status_d[SR4_SEQ_BIT] = seq_d;
      status_d[SR4_PERR_BIT] = perr_d;
      status_d[SR4_EERR_BIT] = eerr_d;
      status_d[SR4_XIP_BIT] = xip_d;
      status_d[SR4_WRAP_LSB +: WRAP_W] = wrap_d;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_q <= PWR_ACTIVE;
         pdm_q <= RST_PDM;
         xip_q <= RST_XIP;
         seq_q <= 1'b0;
         perr_q <= 1'b0;
         eerr_q <= 1'b0;
         wrap_q <= RST_WRAP;
         seq_addr_q <= 24'h000000;
         status_q <= RST_STATUS;
      end else begin
         pwr_q <= pwr_d;
         pdm_q <= pdm_d;
         xip_q <= xip_d;
         seq_q <= seq_d;
         perr_q <= perr_d;
         eerr_q <= eerr_d;
         wrap_q <= wrap_d;
         seq_addr_q <= seq_addr_d;
         status_q <= status_d;
      end
   end

   // Requests to the array engine and power outputs
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         prog_req_q <= 1'b0;
         prog_addr_q <= 24'h000000;
         prog_data_q <= 8'h00;
         erase_req_q <= 1'b0;
         erase_cmd_q <= 8'h00;
         erase_addr_q <= 24'h000000;
         read_req_q <= 1'b0;
         read_addr_q <= 24'h000000;
         deep_power_down_q <= 1'b0;
         ultra_deep_power_down_q <= 1'b0;
         sram_retain_q <= 1'b1;
         hold_reset_enable_q <= 1'b1;
      end else begin
         prog_req_q <= prog_start;
         if (prog_start) begin
            prog_addr_q <= do_seq_next ? seq_addr_q : addr_q; // R6
            prog_data_q <= do_seq_next ? wr_byte : data_q;
         end
         erase_req_q <= do_erase;
         if (do_erase) begin
            erase_cmd_q <= cmd_q;
            erase_addr_q <= addr_q;
         end
         read_req_q <= do_read;
         if (do_read) begin
            read_addr_q <= addr_q;
         end
         deep_power_down_q <= (pwr_d == PWR_DEEP); // R2
         ultra_deep_power_down_q <= (pwr_d == PWR_ULTRA); // R1
         sram_retain_q <= (pwr_d != PWR_ULTRA); // R1 R2
         hold_reset_enable_q <= ~quad_enable; // R15
      end
   end

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   property p_pd_ultra;
      do_pd && !pdm_q |=> ultra_deep_power_down_q && !sram_retain_q && !deep_power_down_q;
   endproperty
   a_pd_ultra: assert property (p_pd_ultra) else $error("power-down with select 0 not ultra-deep"); // R1

   property p_pd_deep;
      do_pd && pdm_q |=> deep_power_down_q && sram_retain_q && !ultra_deep_power_down_q;
   endproperty
   a_pd_deep: assert property (p_pd_deep) else $error("power-down with select 1 not deep"); // R2

   property p_resume_only;
      (pwr_q != PWR_ACTIVE) && !do_resume |=> $stable(pwr_q) && (pwr_q != PWR_ACTIVE);
   endproperty
   a_resume_only: assert property (p_resume_only) else $error("left power-down without resume"); // R3

   property p_resume_wakes;
      do_resume |=> !deep_power_down_q && !ultra_deep_power_down_q && sram_retain_q;
   endproperty
   a_resume_wakes: assert property (p_resume_wakes) else $error("resume did not wake"); // R3

   property p_cs_toggle;
      (pwr_q != PWR_ACTIVE) && frame_end && (cmd_q != CMD_RESUME) |=> (pwr_q != PWR_ACTIVE);
   endproperty
   a_cs_toggle: assert property (p_cs_toggle) else $error("woke on frame without resume"); // R4

   property p_seq_reset;
      $past(sys_rst) |-> !status_q[SR4_SEQ_BIT] && !status_q[SR4_XIP_BIT];
   endproperty
   a_seq_reset: assert property (p_seq_reset) else $error("bad mode flags after reset"); // R5 R9

   property p_seq_enter;
      do_seq_first |=> status_q[SR4_SEQ_BIT] && prog_req_q && (prog_addr_q == $past(addr_q));
   endproperty
   a_seq_enter: assert property (p_seq_enter) else $error("sequential entry wrong"); // R5 R6

   property p_seq_run;
      do_seq_next |=> prog_req_q && (prog_addr_q == $past(seq_addr_q)) && (seq_addr_q == prog_addr_q + 24'h1);
   endproperty
   a_seq_run: assert property (p_seq_run) else $error("sequential address did not run on"); // R6

   property p_perr;
      prog_fail |=> status_q[SR4_PERR_BIT] ##1 (status_q[SR4_PERR_BIT] || $past(prog_start));
   endproperty
   a_perr: assert property (p_perr) else $error("program error flag not set"); // R7

   property p_eerr;
      erase_fail |=> status_q[SR4_EERR_BIT];
   endproperty
   a_eerr: assert property (p_eerr) else $error("erase error flag not set"); // R8

   property p_err_hold;
      status_q[SR4_PERR_BIT] && !prog_start |=> status_q[SR4_PERR_BIT];
   endproperty
   a_err_hold: assert property (p_err_hold) else $error("program error dropped early"); // R16

   property p_err_clear;
      prog_start && !prog_fail |=> !status_q[SR4_PERR_BIT];
   endproperty
   a_err_clear: assert property (p_err_clear) else $error("program error not cleared by start"); // R16

   property p_xip_write;
      do_wrsr |=> (status_q[SR4_XIP_BIT] == $past(wr_byte[SR4_XIP_BIT])) && (xip_q == status_q[SR4_XIP_BIT]);
   endproperty
   a_xip_write: assert property (p_xip_write) else $error("continuous-read enable not written"); // R9

   property p_wrap;
      do_wrap |=> status_q[SR4_WRAP_LSB +: WRAP_W] == $past(data_q[WRAP_CTRL_LSB +: WRAP_W]);
   endproperty
   a_wrap: assert property (p_wrap) else $error("burst wrap field not mirrored"); // R13

   property p_wrap_reset;
      $past(sys_rst) |-> status_q[SR4_WRAP_LSB +: WRAP_W] == RST_WRAP;
   endproperty
   a_wrap_reset: assert property (p_wrap_reset) else $error("burst wrap default wrong"); // R13

   property p_read_quad;
      read_req_q |-> $past(quad_enable) && $past(frame_end);
   endproperty
   a_read_quad: assert property (p_read_quad) else $error("quad read without quad enable"); // R12

   property p_hold;
      quad_enable [*2] |-> !hold_reset_enable_q;
   endproperty
   a_hold: assert property (p_hold) else $error("hold/reset active with quad enable"); // R15

   property p_ultra_deep_power_down;
      do_ultra_deep_power_down |=> ultra_deep_power_down_q && !sram_retain_q && !deep_power_down_q;
   endproperty
   a_ultra_deep_power_down: assert property (p_ultra_deep_power_down) else $error("ultra-deep command not ultra-deep"); // R1

   property p_eerr_hold;
      status_q[SR4_EERR_BIT] && !do_erase |=> status_q[SR4_EERR_BIT];
   endproperty
   a_eerr_hold: assert property (p_eerr_hold) else $error("erase error dropped early"); // R16

   property p_eerr_clear;
      do_erase && !erase_fail |=> !status_q[SR4_EERR_BIT];
   endproperty
   a_eerr_clear: assert property (p_eerr_clear) else $error("erase error not cleared by start"); // R16

   property p_wrdi;
      do_wrdi |=> !status_q[SR4_SEQ_BIT];
   endproperty
   a_wrdi: assert property (p_wrdi) else $error("sequential flag not cleared"); // R5

   property p_hold_off;
      !quad_enable [*2] |-> hold_reset_enable_q;
   endproperty
   a_hold_off: assert property (p_hold_off) else $error("hold/reset off without quad enable"); // R15

   c_deep: cover property (do_pd && pdm_q ##[1:300] do_resume);
   c_ultra: cover property (do_pd && !pdm_q);
   c_seq: cover property (do_seq_first ##[1:600] do_seq_next);
   c_xip: cover property (do_read && xip_frame_q);
endmodule : fsrfc_ctrl

// file: hw/fsrfc_link.sv
// Serial link front end on the serial clock: frame capture and status shift-out
`timescale 1ns/1ps
module fsrfc_link import fsrfc_pkg::*; (
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic sys_rst,
   input wire logic [3:0] io_in,
   input wire logic [7:0] status_in,
   input wire logic quad_enable,
   output logic [3:0] io_out,
   output logic [3:0] io_oe,
   output logic [7:0] cmd_q,
   output logic [23:0] addr_q,
   output logic [7:0] data_q,
   output logic [2:0] nbytes_q,
   output logic xip_frame_q,
   output logic frame_tog_q
);
   logic frame_rst;
   logic [7:0] stat_s1_q, stat_s2_q;
   logic qe_s1_q, qe_s2_q;
   logic started_q, quad_q, out_sel_q, xip_arm_q;
   logic [2:0] bit_q, pos_q;
   logic [7:0] sh_q;
   logic xip_ok, xip_start, quad_now, byte_done, is_qread;
   logic [2:0] pos_cur, pos_inc, bit_step;
   logic [7:0] sh_next;

   assign frame_rst = sys_rst | spi_cs_n;
   assign xip_ok = stat_s2_q[SR4_XIP_BIT] & qe_s2_q; // R12
   assign xip_start = ~started_q & xip_arm_q & xip_ok; // R10
   assign quad_now = started_q ? quad_q : xip_start;
   assign bit_step = quad_now ? 3'h4 : 3'h1;
   // Most significant bit first on one or four lines
   assign sh_next = quad_now ? {sh_q[3:0], io_in} : {sh_q[6:0], io_in[0]}; // R14 R11
   assign byte_done = quad_now ? (bit_q == 3'h4) : (bit_q == 3'h7);
   assign pos_cur = started_q ? pos_q : (xip_start ? 3'h1 : 3'h0);
   assign pos_inc = (pos_cur == NB_DATA) ? pos_cur : pos_cur + 3'h1;
   assign is_qread = (sh_next == CMD_QREAD_E7) | (sh_next == CMD_QREAD_EB);

   // Quasi-static levels into the serial clock domain
   always_ff @(posedge spi_sck or posedge sys_rst) begin
      if (sys_rst) begin
         stat_s1_q <= RST_STATUS;
         stat_s2_q <= RST_STATUS;
         qe_s1_q <= 1'b0;
         qe_s2_q <= 1'b0;
      end else begin
         stat_s1_q <= status_in;
         stat_s2_q <= stat_s1_q;
         qe_s1_q <= quad_enable;
         qe_s2_q <= qe_s1_q;
      end
   end

   // Per-frame shifter, cleared while chip select is high
   always_ff @(posedge spi_sck or posedge frame_rst) begin
      if (frame_rst) begin
         started_q <= 1'b0;
         bit_q <= 3'h0;
         pos_q <= 3'h0;
         sh_q <= 8'h00;
         quad_q <= 1'b0;
         out_sel_q <= 1'b0;
      end else begin
         started_q <= 1'b1;
         bit_q <= bit_q + bit_step;
         sh_q <= sh_next;
         pos_q <= byte_done ? pos_inc : pos_cur;
         if (!started_q) begin
            quad_q <= xip_start;
         end
         if (byte_done && pos_cur == 3'h0) begin
            quad_q <= is_qread & qe_s2_q; // R11
            out_sel_q <= (sh_next == CMD_READ_SR4);
         end
      end
   end

   // Frame fields, held after chip select rises
   always_ff @(posedge spi_sck or posedge sys_rst) begin
      if (sys_rst) begin
         cmd_q <= 8'h00;
         addr_q <= 24'h000000;
         data_q <= 8'h00;
         nbytes_q <= 3'h0;
         xip_frame_q <= 1'b0;
         xip_arm_q <= 1'b0;
         frame_tog_q <= 1'b0;
      end else begin
         if (!started_q) begin
            nbytes_q <= 3'h0;
            xip_frame_q <= xip_start;
            // Flips once per frame that carries clock edges
            frame_tog_q <= ~frame_tog_q;
            if (!xip_ok) begin
               xip_arm_q <= 1'b0; // R12
            end
         end
         if (byte_done) begin
            nbytes_q <= pos_inc;
            case (pos_cur)
               3'h0: cmd_q <= sh_next;
               3'h1: addr_q[23:16] <= sh_next;
               3'h2: addr_q[15:8] <= sh_next;
               3'h3: addr_q[7:0] <= sh_next;
               3'h4: data_q <= sh_next;
               default: data_q <= data_q;
            endcase
            if (pos_cur == 3'h4 && quad_q) begin
               xip_arm_q <= (sh_next[XIP_MODE_LSB +: 2] == XIP_MODE_KEEP) & xip_ok; // R10
            end
         end
      end
   end

   // Status shift-out on the falling edge, lane one
   always_ff @(negedge spi_sck or posedge frame_rst) begin
      if (frame_rst) begin
         io_out <= 4'h0;
         io_oe <= 4'h0;
      end else begin
         io_out <= {2'b00, out_sel_q & stat_s2_q[3'h7 - bit_q], 1'b0}; // R14
         io_oe <= {2'b00, out_sel_q, 1'b0};
      end
   end
endmodule : fsrfc_link

// file: hw/fsrfc_pkg.sv
// Constants and types for the status register four controller
package fsrfc_pkg;
   // Command bytes
   localparam logic [7:0] CMD_POWER_DOWN = 8'hb9;
   localparam logic [7:0] CMD_ULTRA_DEEP = 8'h79;
   localparam logic [7:0] CMD_RESUME = 8'hab;
   localparam logic [7:0] CMD_SET_WRAP = 8'h77;
   localparam logic [7:0] CMD_QREAD_E7 = 8'he7;
   localparam logic [7:0] CMD_QREAD_EB = 8'heb;
   localparam logic [7:0] CMD_PAGE_PROG = 8'h02;
   localparam logic [7:0] CMD_SEQ_PROG = 8'had;
   localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] CMD_ERASE_4K = 8'h20;
   localparam logic [7:0] CMD_ERASE_32K = 8'h52;
   localparam logic [7:0] CMD_ERASE_64K = 8'hd8;
   localparam logic [7:0] CMD_ERASE_CHIP = 8'hc7;
   localparam logic [7:0] CMD_READ_SR4 = 8'h3d;
   localparam logic [7:0] CMD_WRITE_SR4 = 8'h3e;
   // Field positions of power_program_xip_status
   localparam int SR4_PDM_BIT = 7;
   localparam int SR4_SEQ_BIT = 6;
   localparam int SR4_PERR_BIT = 5;
   localparam int SR4_EERR_BIT = 4;
   localparam int SR4_XIP_BIT = 3;
   localparam int SR4_WRAP_LSB = 0;
   localparam int WRAP_W = 3;
   localparam int WRAP_CTRL_LSB = 4;
   // Reset values
   localparam logic RST_PDM = 1'b0;
   localparam logic RST_XIP = 1'b0;
   localparam logic [2:0] RST_WRAP = 3'h1;
   localparam logic [7:0] RST_STATUS = 8'h01;
   // Continuous-read mode byte
   localparam int XIP_MODE_LSB = 4;
   localparam logic [1:0] XIP_MODE_KEEP = 2'h2;
   // Frame byte counts
   localparam logic [2:0] NB_CMD = 3'h1;
   localparam logic [2:0] NB_ONE = 3'h2;
   localparam logic [2:0] NB_ADDR = 3'h4;
   localparam logic [2:0] NB_DATA = 3'h5;
   typedef enum logic [1:0] {PWR_ACTIVE, PWR_DEEP, PWR_ULTRA} fsrfc_power_type;
endpackage : fsrfc_pkg

// file: test/fsrfc_host.sv
// Host controller model driving the serial flash link in mode 0
`timescale 1ns/1ps
module fsrfc_host (
   output logic spi_sck,
   output logic spi_cs_n,
   output logic [3:0] io_in,
   input wire logic [3:0] io_out,
   input wire logic [3:0] io_oe
);
   initial begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      io_in = 4'h5;
   end

   // Present lines after the falling edge, sample read data at the rising edge
   task automatic edge_io(input logic [3:0] v, inout logic [7:0] rd);
      io_in = v;
      #6;
      spi_sck = 1'b1;
      rd = {rd[6:0], io_out[1] & io_oe[1]};
      #6;
      spi_sck = 1'b0;
   endtask : edge_io

   // Bytes leave from the top of b; from byte qf on, a nibble per edge
   task automatic xfer(input logic [39:0] b, input int n, input int qf, output logic [7:0] rd);
      logic [7:0] cur;
      rd = 8'h00;
      spi_cs_n = 1'b0;
      #6;
      for (int i = 0; i < n; i++) begin
         cur = b[39 - 8 * i -: 8];
         if (i >= qf) begin
            edge_io(cur[7:4], rd);
            edge_io(cur[3:0], rd);
         end else begin
            for (int k = 7; k >= 0; k--) edge_io({~io_in[3:1], cur[k]}, rd);
         end
      end
      spi_cs_n = 1'b1;
      // Released lines show no stale value
      io_in = ~io_in;
      #200;
   endtask : xfer
endmodule : fsrfc_host

// file: test/tb.sv
// Self-checking bench for the status register four controller
`timescale 1ns/1ps
module tb;
   import fsrfc_pkg::*;
   logic clock;
   logic sys_rst;
   logic quad_enable;
   logic prog_fail;
   logic erase_fail;
   logic spi_sck;
   logic spi_cs_n;
   logic [3:0] io_in;
   logic [3:0] io_out;
   logic [3:0] io_oe;
   logic prog_req_q;
   logic [23:0] prog_addr_q;
   logic [7:0] prog_data_q;
   logic erase_req_q;
   logic [7:0] erase_cmd_q;
   logic [23:0] erase_addr_q;
   logic read_req_q;
   logic [23:0] read_addr_q;
   logic deep_power_down_q;
   logic ultra_deep_power_down_q;
   logic sram_retain_q;
   logic hold_reset_enable_q;
   logic [7:0] status_q;
   logic [7:0] rd_last;
   logic [7:0] qcmd;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   int n_prog = 0;
   int n_erase = 0;
   int n_read = 0;
   int p0;

   fsrfc_ctrl uut (.clock(clock), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .quad_enable(quad_enable), .prog_fail(prog_fail),
      .erase_fail(erase_fail), .prog_req_q(prog_req_q), .prog_addr_q(prog_addr_q),
      .prog_data_q(prog_data_q), .erase_req_q(erase_req_q), .erase_cmd_q(erase_cmd_q),
      .erase_addr_q(erase_addr_q), .read_req_q(read_req_q), .read_addr_q(read_addr_q),
      .deep_power_down_q(deep_power_down_q), .ultra_deep_power_down_q(ultra_deep_power_down_q),
      .sram_retain_q(sram_retain_q), .hold_reset_enable_q(hold_reset_enable_q), .status_q(status_q));

   fsrfc_host host (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (prog_req_q === 1'b1) n_prog++;
      if (erase_req_q === 1'b1) n_erase++;
      if (read_req_q === 1'b1) n_read++;
      if (cycles == 8000) begin
         miscompares++;
         $display("[ERR] %0t run did not finish in time", $time);
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // One frame, then time for the result to cross
   task automatic op(input logic [39:0] b, input int n, input int qf);
      host.xfer(b, n, qf, rd_last);
      repeat (5) @(negedge clock);
   endtask : op

   task automatic pulse_fail(input logic pe);
      @(negedge clock);
      prog_fail = pe;
      erase_fail = ~pe;
      @(negedge clock);
      prog_fail = 1'b0;
      erase_fail = 1'b0;
      repeat (3) @(negedge clock);
   endtask : pulse_fail

   initial begin
      sys_rst = 1'b1;
      quad_enable = 1'b0;
      prog_fail = 1'b0;
      erase_fail = 1'b0;
      repeat (6) @(negedge clock);
      sys_rst = 1'b0;
      repeat (2) @(negedge clock);
      chk(status_q, RST_STATUS);
      chk({sram_retain_q, hold_reset_enable_q}, 2'h3);
      op({CMD_READ_SR4, 32'h0}, 2, 9);
      chk(rd_last, 8'h01);
      op({CMD_WRITE_SR4, 8'h88, 24'h0}, 2, 9);
      chk(status_q, 8'h89);
      for (int d = 0; d < 2; d++) begin
         op({CMD_WRITE_SR4, d[0], 7'h00, 24'h0}, 2, 9);
         op({CMD_POWER_DOWN, 32'h0}, 1, 9);
         op({CMD_WRITE_SR4, 8'h08, 24'h0}, 2, 9);
         op(40'h0, 0, 9);
         chk({deep_power_down_q, ultra_deep_power_down_q, sram_retain_q, status_q}, {d[0], ~d[0], d[0], d[0], 7'h01});
         op({CMD_RESUME, 32'h0}, 1, 9);
         chk({deep_power_down_q, ultra_deep_power_down_q, sram_retain_q}, 3'h1);
      end
      op({CMD_ULTRA_DEEP, 32'h0}, 1, 9);
      chk({deep_power_down_q, ultra_deep_power_down_q, sram_retain_q}, 3'h2);
      op({CMD_RESUME, 32'h0}, 1, 9);
      p0 = n_prog;
      op({CMD_PAGE_PROG, 24'h123456, 8'ha5}, 4, 9);
      chk(8'(n_prog - p0), 8'h00);
      op({CMD_PAGE_PROG, 24'h123456, 8'ha5}, 5, 9);
      chk({8'(n_prog - p0), prog_addr_q, prog_data_q}, {8'h01, 24'h123456, 8'ha5});
      pulse_fail(1'b1);
      chk(status_q[5], 1'b1);
      p0 = n_erase;
      op({CMD_ERASE_4K, 24'h001000, 8'h00}, 4, 9);
      pulse_fail(1'b0);
      chk({7'(n_erase - p0), erase_cmd_q, erase_addr_q, status_q[4]}, {7'h01, CMD_ERASE_4K, 24'h001000, 1'b1});
      op({CMD_ERASE_CHIP, 32'h0}, 1, 9);
      chk({7'(n_erase - p0), erase_cmd_q, status_q[4]}, {7'h02, CMD_ERASE_CHIP, 1'b0});
      op({CMD_PAGE_PROG, 24'h000020, 8'h3c}, 5, 9);
      chk(status_q[5], 1'b0);
      p0 = n_prog;
      op(40'h0, 0, 9);
      chk(8'(n_prog - p0), 8'h00);
      op({CMD_SEQ_PROG, 24'h000010, 8'h11}, 5, 9);
      op({CMD_SEQ_PROG, 8'h22, 24'h0}, 2, 9);
      chk({status_q[6], prog_addr_q, prog_data_q}, {1'b1, 24'h000011, 8'h22});
      op({CMD_WRITE_DISABLE, 32'h0}, 1, 9);
      chk(status_q[6], 1'b0);
      op({CMD_SET_WRAP, 24'h0, 8'h50}, 5, 9);
      chk(status_q[2:0], 3'h5);
      for (int j = 0; j < 2; j++) begin
         qcmd = j[0] ? CMD_QREAD_EB : CMD_QREAD_E7;
         op({CMD_WRITE_SR4, 4'h0, j[0], 3'h0, 24'h0}, 2, 9);
         quad_enable = 1'b1;
         p0 = n_read;
         op({qcmd, 24'h000200, 8'h20}, 5, 1);
         chk({8'(n_read - p0), read_addr_q, hold_reset_enable_q}, {8'h01, 24'h000200, 1'b0});
         // Command-less frame: taken only with the enable bit set
         op({24'h000300, 8'h20, 8'h00}, 4, 0);
         chk({8'(n_read - p0), read_addr_q}, {j[0] ? 8'h02 : 8'h01, j[0] ? 24'h000300 : 24'h000200});
         quad_enable = 1'b0;
         repeat (2) @(negedge clock);
         op({24'h000400, 8'h20, 8'h00}, 4, 0);
         chk(8'(n_read - p0), j[0] ? 8'h02 : 8'h01);
      end
      chk(hold_reset_enable_q, 1'b1);
      print_verdict();
   end
endmodule : tb
